/* File: verilog/pubs_params.svh */
// constants for the power-up boot sequencer
`ifndef PUBS_PARAMS_SVH
`define PUBS_PARAMS_SVH

`define PUBS_RESET_VECTOR 32'h8000_0000
`define PUBS_NUM_PLL 2
`define PUBS_NUM_DOM 4
`define PUBS_NUM_GATE 8
`define PUBS_DIV_W 3
`define PUBS_CNT_W 8
`define PUBS_PLL_RST 2'h0
`define PUBS_DIV_RST 3'h0
`define PUBS_GATE_RST 8'hff

`endif

/* File: verilog/pubs_pkg.sv */
// types shared by the power-up boot sequencer
`default_nettype none
`include "pubs_params.svh"

package pubs_pkg;

	typedef enum logic [1:0] {
		PUBS_SRC_RC,
		PUBS_SRC_PLL0,
		PUBS_SRC_PLL1
	} pubs_src_t;

	typedef enum logic [1:0] {
		PUBS_OP_PLL,
		PUBS_OP_DIV,
		PUBS_OP_GATE,
		PUBS_OP_SRC
	} pubs_op_t;

	// firmware clock-control command
	typedef struct packed {
		logic valid;
		pubs_op_t op;
		logic [2:0] idx;
		logic [7:0] data;
	} pubs_cmd_t;

	// supply status inputs
	typedef struct packed {
		logic por_active;
		logic pwr_stable;
		logic io_supply_ok;
		logic core_ok;
	} pubs_supply_t;

	// live clock configuration
	typedef struct packed {
		logic [`PUBS_NUM_PLL-1:0] pll_en;
		pubs_src_t src;
		logic [`PUBS_NUM_DOM-1:0][`PUBS_DIV_W-1:0] div;
		logic [`PUBS_NUM_GATE-1:0] gate;
	} pubs_clk_cfg_t;

endpackage : pubs_pkg

`default_nettype wire

/* File: verilog/pubs_rst_sync.sv */
// reset release synchroniser: async assert, two-stage clocked release
`timescale 1ns/1ps
`default_nettype none

module pubs_rst_sync (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_hold,
	output logic o_release
);
	logic stage1;

	// first stage feeds only the second
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stage1 <= 1'b0;
		end else begin
			stage1 <= !i_hold;
		end
	end

	// hold drops release at the next clock edge, not after two stages
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_release <= 1'b0;
		end else if (i_hold) begin
			o_release <= 1'b0;
		end else begin
			o_release <= stage1;
		end
	end
endmodule : pubs_rst_sync

`default_nettype wire

/* File: verilog/pubs_top.sv */
// power-up boot sequencer: reset release, boot clock setup, fetch start
// Summary of operation
// - system held reset until power stable
// - rc oscillator is clock once stable
// - plls disabled until firmware enables them
// - all module clocks running after start-up
// - dividers pass through after start-up
// - cpu fetches first at flash base
// - io supply monitor low keeps reset
// - firmware may enable plls, divide, gate
// - cpu runs once above por threshold with io supply ok
`timescale 1ns/1ps
`default_nettype none
`include "pubs_params.svh"

module pubs_top (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire pubs_pkg::pubs_supply_t i_supply,
	input wire pubs_pkg::pubs_cmd_t i_cmd,
	output logic o_cpu_nrst,
	output logic o_sys_nrst,
	output logic o_fetch_start,
	output logic [31:0] o_fetch_addr,
	output pubs_pkg::pubs_clk_cfg_t o_clk_cfg,
	output logic [`PUBS_NUM_DOM-1:0] o_dom_en,
	output logic o_cmd_refused
);
	import pubs_pkg::*;

	typedef enum logic [1:0] {
		ST_HOLD,
		ST_BOOT,
		ST_RUN
	} pubs_state_t;

	pubs_state_t state;
	logic cpu_hold;
	logic sys_hold;
	logic cpu_rel;
	logic sys_rel;
	logic fast_ok;
	logic [`PUBS_CNT_W-1:0] div_cnt [`PUBS_NUM_DOM];

	function automatic logic [`PUBS_CNT_W-1:0] div_mask(input logic [`PUBS_DIV_W-1:0] d);
		logic [15:0] m;
		m = (16'h1 << d) - 16'h1;
		return m[`PUBS_CNT_W-1:0];
	endfunction : div_mask

	assign cpu_hold = i_supply.por_active | !i_supply.io_supply_ok;
	assign sys_hold = cpu_hold | !i_supply.pwr_stable;
	assign fast_ok = i_supply.pwr_stable & i_supply.core_ok;

	pubs_rst_sync u_cpu_sync (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_hold(cpu_hold),
		.o_release(cpu_rel)
	);

	pubs_rst_sync u_sys_sync (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_hold(sys_hold),
		.o_release(sys_rel)
	);

	assign o_cpu_nrst = cpu_rel;
	assign o_sys_nrst = sys_rel;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= ST_HOLD;
		end else if (!cpu_rel) begin
			state <= ST_HOLD;
		end else begin
			unique case (state)
				ST_HOLD: begin
					state <= ST_BOOT;
				end
				ST_BOOT: begin
					state <= ST_RUN;
				end
				ST_RUN: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_fetch_start <= 1'b0;
			o_fetch_addr <= `PUBS_RESET_VECTOR;
		end else begin
			o_fetch_start <= cpu_rel && (state == ST_HOLD);
			o_fetch_addr <= `PUBS_RESET_VECTOR;
		end
	end

	// config returns to boot defaults whenever the cpu is in reset
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_clk_cfg.pll_en <= `PUBS_PLL_RST;
			o_clk_cfg.src <= PUBS_SRC_RC;
			o_clk_cfg.div <= '0;
			o_clk_cfg.gate <= `PUBS_GATE_RST;
			o_cmd_refused <= 1'b0;
		end else if (!cpu_rel) begin
			o_clk_cfg.pll_en <= `PUBS_PLL_RST;
			o_clk_cfg.src <= PUBS_SRC_RC;
			for (int i = 0; i < `PUBS_NUM_DOM; i++) begin
				o_clk_cfg.div[i] <= `PUBS_DIV_RST;
			end
			o_clk_cfg.gate <= `PUBS_GATE_RST;
			o_cmd_refused <= 1'b0;
		end else begin
			o_cmd_refused <= 1'b0;
			if (i_cmd.valid) begin
				unique case (i_cmd.op)
					PUBS_OP_PLL: begin
						o_clk_cfg.pll_en[i_cmd.idx[0]] <= i_cmd.data[0];
						// dropping the live pll falls back to rc, never a dead clock
						if (!i_cmd.data[0] && (o_clk_cfg.src != PUBS_SRC_RC)
								&& (o_clk_cfg.src[1] == i_cmd.idx[0])) begin
							o_clk_cfg.src <= PUBS_SRC_RC;
						end
					end
					PUBS_OP_DIV: begin
						o_clk_cfg.div[i_cmd.idx[1:0]] <= i_cmd.data[`PUBS_DIV_W-1:0];
					end
					PUBS_OP_GATE: begin
						o_clk_cfg.gate[i_cmd.idx] <= i_cmd.data[0];
					end
					PUBS_OP_SRC: begin
						if (i_cmd.data[1:0] == 2'h0) begin
							o_clk_cfg.src <= PUBS_SRC_RC;
						end else if (i_cmd.data[1:0] == 2'h3) begin
							o_cmd_refused <= 1'b1;
						end else if (fast_ok && o_clk_cfg.pll_en[i_cmd.data[1]]) begin
							o_clk_cfg.src <= pubs_src_t'(i_cmd.data[1:0]);
						end else begin
							o_cmd_refused <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_dom_en <= '0;
			for (int i = 0; i < `PUBS_NUM_DOM; i++) begin
				div_cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < `PUBS_NUM_DOM; i++) begin
				if ((div_cnt[i] & div_mask(o_clk_cfg.div[i])) == div_mask(o_clk_cfg.div[i])) begin
					div_cnt[i] <= '0;
					o_dom_en[i] <= 1'b1;
				end else begin
					div_cnt[i] <= div_cnt[i] + 8'h01;
					o_dom_en[i] <= 1'b0;
				end
			end
		end
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	io_hold_rst_a: assert property (cpu_hold |=> !o_cpu_nrst)
		else $error("cpu reset not held while supply low");

	sys_hold_rst_a: assert property (!i_supply.pwr_stable |=> !o_sys_nrst)
		else $error("system reset released before power stable");

	sync_release_a: assert property ($rose(o_cpu_nrst) |-> $past(!cpu_hold) && $past(!cpu_hold, 2))
		else $error("cpu release not synchronised");

	// sampled reset level keeps the release edge itself out of the count
	early_cpu_run_a: assert property ((i_nrst && !cpu_hold) [*2] |=> o_cpu_nrst)
		else $error("cpu held despite supply above threshold");

	fetch_vector_a: assert property ($rose(o_cpu_nrst) |=> o_fetch_start && o_fetch_addr == `PUBS_RESET_VECTOR)
		else $error("fetch not started at reset vector");

	pll_off_rst_a: assert property (!o_cpu_nrst |=> o_clk_cfg.pll_en == `PUBS_PLL_RST)
		else $error("pll enabled during reset");

	rc_select_a: assert property (!o_cpu_nrst |=> o_clk_cfg.src == PUBS_SRC_RC)
		else $error("clock source not rc at start");

	gates_on_a: assert property (!o_cpu_nrst |=> o_clk_cfg.gate == `PUBS_GATE_RST)
		else $error("module clock gated at start");

	div_pass_a: assert property (!o_cpu_nrst [*2] |=> o_dom_en == 4'hf)
		else $error("divider not pass-through at start");

	fast_guard_a: assert property ($changed(o_clk_cfg.src) && o_clk_cfg.src != PUBS_SRC_RC
			|-> $past(fast_ok))
		else $error("fast clock selected without core supply check");

	gate_cmd_a: assert property (o_cpu_nrst && cpu_rel && !cpu_hold && i_cmd.valid
			&& i_cmd.op == PUBS_OP_GATE |=> o_clk_cfg.gate[$past(i_cmd.idx)] == $past(i_cmd.data[0]))
		else $error("gate command not applied");

	boot_cov: cover property ($rose(o_cpu_nrst) ##[1:50] $rose(o_sys_nrst));
	pll_cov: cover property (o_clk_cfg.src == PUBS_SRC_PLL0);
	refuse_cov: cover property (o_cmd_refused);
	brownout_cov: cover property (o_cpu_nrst ##1 !o_cpu_nrst);
endmodule : pubs_top

`default_nettype wire

/* File: tb/pubs_tb.sv */
// self-checking bench for the power-up boot sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pubs_params.svh"
module testbench;
	import pubs_pkg::*;
	logic i_ref_clk, i_nrst, o_cpu_nrst, o_sys_nrst, o_fetch_start, o_cmd_refused, rf;
	pubs_supply_t i_supply;
	pubs_cmd_t i_cmd;
	logic [31:0] o_fetch_addr;
	pubs_clk_cfg_t o_clk_cfg, exp;
	logic [`PUBS_NUM_DOM-1:0] o_dom_en;
	int n_fail, checks_done, cyc, i, np;
	pubs_top dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_supply(i_supply), .i_cmd(i_cmd),
		.o_cpu_nrst(o_cpu_nrst), .o_sys_nrst(o_sys_nrst), .o_fetch_start(o_fetch_start),
		.o_fetch_addr(o_fetch_addr), .o_clk_cfg(o_clk_cfg), .o_dom_en(o_dom_en),
		.o_cmd_refused(o_cmd_refused));
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	task automatic give_verdict();
		if (n_fail == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask : chk
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			give_verdict();
		end
	end
	// model of the clock controls, updated per command
	task automatic cmd(input pubs_op_t op, input logic [2:0] idx, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_cmd <= '{1'b1, op, idx, d};
		@(posedge i_ref_clk);
		i_cmd.valid <= 1'b0;
		rf = 1'b0;
		case (op)
			PUBS_OP_PLL: begin
				exp.pll_en[idx[0]] = d[0];
				if (!d[0] && exp.src == (idx[0] ? PUBS_SRC_PLL1 : PUBS_SRC_PLL0))
					exp.src = PUBS_SRC_RC;
			end
			PUBS_OP_DIV: exp.div[idx[1:0]] = d[2:0];
			PUBS_OP_GATE: exp.gate[idx] = d[0];
			default: begin
				// fast source only with core supply confirmed and pll running
				rf = d[1:0] == 2'h3 || (d[1:0] != 2'h0 &&
					!(i_supply.pwr_stable && i_supply.core_ok && exp.pll_en[d[1]]));
				if (!rf) exp.src = pubs_src_t'(d[1:0]);
			end
		endcase
		@(negedge i_ref_clk);
		chk("clk_cfg", 32'(o_clk_cfg), 32'(exp));
		chk("cmd_refused", 32'(o_cmd_refused), 32'(rf));
	endtask : cmd
	// waits for cpu release, then checks the fetch pulse
	// n_neg: falling edges from the call until release shows, two edges of clear hold
	task automatic wait_release(input int n_neg);
		for (i = 0; i < 6 && o_cpu_nrst !== 1'b1; i++) @(negedge i_ref_clk);
		chk("cpu_nrst", 32'(o_cpu_nrst), 32'h1);
		chk("release delay", i, n_neg);
		@(negedge i_ref_clk);
		chk("fetch_start", 32'(o_fetch_start), 32'h1);
		chk("fetch_addr", o_fetch_addr, `PUBS_RESET_VECTOR);
		@(negedge i_ref_clk);
		chk("fetch_end", 32'(o_fetch_start), 32'h0);
	endtask : wait_release
	initial begin
		i_nrst = 1'b0;
		i_supply = '{1'b1, 1'b0, 1'b0, 1'b0};
		i_cmd = '0;
		exp = '0;
		exp.gate = `PUBS_GATE_RST;
		void'($urandom(32'h77eb2a9b));
		repeat (2) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk("reset cfg", 32'(o_clk_cfg), 32'(exp));
		chk("reset cpu", 32'(o_cpu_nrst), 32'h0);
		@(posedge i_ref_clk);
		i_nrst <= 1'b1;
		repeat (4) @(negedge i_ref_clk);
		chk("por hold", 32'(o_cpu_nrst), 32'h0);
		chk("dom_en", 32'(o_dom_en), 32'hf);
		@(posedge i_ref_clk);
		i_supply.por_active <= 1'b0;
		repeat (4) @(negedge i_ref_clk);
		chk("io hold", 32'(o_cpu_nrst), 32'h0);
		@(posedge i_ref_clk);
		i_supply.io_supply_ok <= 1'b1;
		// called on the edge that lowers hold: seen high at the third falling edge
		wait_release(3);
		chk("sys_nrst early", 32'(o_sys_nrst), 32'h0);
		@(posedge i_ref_clk);
		i_supply.pwr_stable <= 1'b1;
		repeat (4) @(negedge i_ref_clk);
		chk("sys_nrst", 32'(o_sys_nrst), 32'h1);
		cmd(PUBS_OP_SRC, 3'h0, 8'h01);
		cmd(PUBS_OP_PLL, 3'h0, 8'h01);
		cmd(PUBS_OP_SRC, 3'h0, 8'h01);
		@(posedge i_ref_clk);
		i_supply.core_ok <= 1'b1;
		cmd(PUBS_OP_SRC, 3'h0, 8'h01);
		cmd(PUBS_OP_SRC, 3'h0, 8'h03);
		cmd(PUBS_OP_PLL, 3'h0, 8'h00);
		for (int k = 0; k < 40; k++) begin
			@(posedge i_ref_clk);
			i_supply.core_ok <= 1'($urandom_range(1));
			cmd(pubs_op_t'($urandom_range(3)), 3'($urandom), 8'($urandom));
		end
		// second pll: select it, then drop it under the live clock
		@(posedge i_ref_clk);
		i_supply.core_ok <= 1'b1;
		cmd(PUBS_OP_PLL, 3'h1, 8'h01);
		cmd(PUBS_OP_SRC, 3'h0, 8'h02);
		cmd(PUBS_OP_PLL, 3'h1, 8'h00);
		// divide by four: first period may be short, so settle before counting
		cmd(PUBS_OP_DIV, 3'h1, 8'h02);
		np = 0;
		repeat (8) @(negedge i_ref_clk);
		repeat (16) begin
			@(negedge i_ref_clk);
			np += int'(o_dom_en[1]);
		end
		chk("dom_en div4", np, 32'h4);
		// a one-cycle por pulse must restart the whole boot
		@(posedge i_ref_clk);
		i_supply.por_active <= 1'b1;
		@(posedge i_ref_clk);
		i_supply.por_active <= 1'b0;
		@(negedge i_ref_clk);
		chk("por pulse", 32'(o_cpu_nrst), 32'h0);
		// called half a cycle after hold fell, so one falling edge fewer
		wait_release(2);
		exp = '0;
		exp.gate = `PUBS_GATE_RST;
		chk("boot cfg", 32'(o_clk_cfg), 32'(exp));
		chk("boot dom_en", 32'(o_dom_en), 32'hf);
		chk("boot sys_nrst", 32'(o_sys_nrst), 32'h1);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
